// ==== hdl/dct_nck_counter.sv ====
// Down counter of link clock edges, loaded with a cycle count.
// Assumes tick is a one-cycle pulse per sampled link clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module dct_nck_counter (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             load,
  input  wire logic [7:0]       load_val,
  input  wire logic             tick,
  // Status
  output logic      [7:0]       count,
  output logic                  busy,
  output logic                  done
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // Load wins over the decrement
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (tick && (cnt_ff != 8'h00)) begin
      nxt_cnt = cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done on the edge that takes the count to zero
  assign count = cnt_ff;
  assign busy  = (cnt_ff != 8'h00);
  assign done  = tick && (cnt_ff == 8'h01) && !load;

endmodule : dct_nck_counter
`default_nettype wire

// ==== hdl/dct_pkg.sv ====
// Constants, field layouts and command codes for the DDR3 command timing block.
// Assumes every ps figure is turned into link clock cycles by rounding up.
package dct_pkg;

  // ----------------------------------------------------------------
  // Sampled pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_W   = 25;
  localparam int P_ADDR  = 0;   // 15 bits of address
  localparam int P_BA    = 15;  // 3 bits of bank
  localparam int P_WE    = 18;
  localparam int P_CAS   = 19;
  localparam int P_RAS   = 20;
  localparam int P_CS    = 21;
  localparam int P_CKE   = 22;
  localparam int P_CK    = 23;
  localparam int P_ZQ    = 24;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MR0_BL_LSB  = 0;
  localparam int MR0_CL_LSB  = 4;
  localparam int MR0_WR_LSB  = 9;
  localparam int MR1_AL_LSB  = 3;
  localparam int MR2_CWL_LSB = 3;
  localparam int A_AP        = 10;
  localparam int A_BC        = 12;

  localparam logic [1:0] MRSEL_0 = 2'h0;
  localparam logic [1:0] MRSEL_1 = 2'h1;
  localparam logic [1:0] MRSEL_2 = 2'h2;

  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_BC4  = 2'h2;

  localparam logic [1:0] AL_CL1  = 2'h1;
  localparam logic [1:0] AL_CL2  = 2'h2;

  // Reset values of the mode fields
  localparam logic [1:0] BL_RST  = 2'h0;
  localparam logic [2:0] CL_RST  = 3'h1;
  localparam logic [2:0] WR_RST  = 3'h1;
  localparam logic [1:0] AL_RST  = 2'h0;
  localparam logic [2:0] CWL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int         CNT_W        = 8;
  localparam logic [7:0] CL_BASE      = 8'h04;
  localparam logic [7:0] CWL_BASE     = 8'h05;
  localparam logic [7:0] WSTART_BL8   = 8'h04;
  localparam logic [7:0] WSTART_BC4   = 8'h02;
  localparam logic [7:0] ZQCS_NCK     = 8'h40;

  // Row and refresh times, plain defaults, in ps of the average link period
  localparam int TCK_AVG_PS = 80000;
  localparam int TRP_PS     = 15000;
  localparam int TRCD_PS    = 15000;
  localparam int TRFC_PS    = 160000;
  localparam logic [7:0] TRP_NCK  = 8'((TRP_PS + TCK_AVG_PS - 1) / TCK_AVG_PS);
  localparam logic [7:0] TRCD_NCK = 8'((TRCD_PS + TCK_AVG_PS - 1) / TCK_AVG_PS);
  localparam logic [7:0] TRFC_NCK = 8'((TRFC_PS + TCK_AVG_PS - 1) / TCK_AVG_PS);

  // Impedance trim, one step is one correction increment
  localparam int         TRIM_W   = 6;
  localparam logic [5:0] TRIM_RST = 6'h20;
  localparam logic [5:0] TRIM_MAX = 6'h3F;
  localparam logic [5:0] TRIM_MIN = 6'h00;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
  } dct_cmd_t;

  // Write recovery code to cycles
  function automatic logic [7:0] wr_code_nck(input logic [2:0] code);
    logic [7:0] n;
    case (code)
      3'h1:    n = 8'h05;
      3'h2:    n = 8'h06;
      3'h3:    n = 8'h07;
      3'h4:    n = 8'h08;
      3'h5:    n = 8'h0A;
      3'h6:    n = 8'h0C;
      3'h7:    n = 8'h0E;
      default: n = 8'h10;
    endcase
    return n;
  endfunction : wr_code_nck

endpackage : dct_pkg

// ==== hdl/dct_timing.sv ====
// Device side of the DDR3 command timing: decodes commands on link clock
// edges, times internal write start, write recovery, ZQ short calibration
// and power-down entry. Assumes the controller keeps its own spacings.
`timescale 1ns/1ps
`default_nettype none
module dct_timing (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Memory pins
  input  wire logic             ck,
  input  wire logic             cke,
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic [2:0]       ba,
  input  wire logic [14:0]      addr,
  // Calibration comparator, high when impedance too high
  input  wire logic             zq_cmp_hi,
  // Internal events
  output logic                  wr_start,
  output logic                  auto_pre,
  output logic      [2:0]       ap_bank,
  // Status
  output logic                  zq_busy,
  output logic                  zq_done,
  output logic      [5:0]       zq_trim,
  output logic                  ops_busy,
  output logic                  pd_active
);

  // ----------------------------------------------------------------
  // Pin synchroniser and link clock edge
  // ----------------------------------------------------------------
  logic [dct_pkg::PIN_W-1:0] s1_ff, s2_ff, s3_ff;
  logic                      ck_lvl_ff, nxt_ck_lvl;
  logic                      ck_rise;

  // Three stages; only the second and third are compared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {zq_cmp_hi, ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Every agreed rise is one nCK; no period is assumed, so stretching is harmless
  always_comb begin
    nxt_ck_lvl = ck_lvl_ff;
    ck_rise    = 1'b0;
    if (s2_ff[dct_pkg::P_CK] == s3_ff[dct_pkg::P_CK]) begin
      nxt_ck_lvl = s3_ff[dct_pkg::P_CK];
      ck_rise    = s3_ff[dct_pkg::P_CK] && !ck_lvl_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_lvl_ff <= 1'b0;
    end else begin
      ck_lvl_ff <= nxt_ck_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [14:0]      a_s;
  logic [2:0]       ba_s;
  dct_pkg::dct_cmd_t cmd;

  assign a_s  = s3_ff[dct_pkg::P_ADDR +: 15];
  assign ba_s = s3_ff[dct_pkg::P_BA +: 3];

  // Commands count only on an edge with CKE high and chip selected
  always_comb begin
    cmd = dct_pkg::CMD_NOP;
    if (ck_rise && s3_ff[dct_pkg::P_CKE] && !s3_ff[dct_pkg::P_CS]) begin
      case ({s3_ff[dct_pkg::P_RAS], s3_ff[dct_pkg::P_CAS], s3_ff[dct_pkg::P_WE]})
        3'h0:    cmd = dct_pkg::CMD_MRS;
        3'h1:    cmd = dct_pkg::CMD_REF;
        3'h2:    cmd = dct_pkg::CMD_PRE;
        3'h3:    cmd = dct_pkg::CMD_ACT;
        3'h4:    cmd = dct_pkg::CMD_WR;
        3'h5:    cmd = dct_pkg::CMD_RD;
        3'h6:    cmd = dct_pkg::CMD_ZQ;
        default: cmd = dct_pkg::CMD_NOP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic       ws_load, rc_load, op_load, zq_load;
  logic [7:0] ws_val, rc_val, op_val;
  logic [7:0] op_count;
  logic       ws_busy, rc_busy;
  logic       ws_done, rc_done;

  dct_nck_counter u_wstart (
    .clk(clk), .rst(rst), .load(ws_load), .load_val(ws_val), .tick(ck_rise),
    .count(), .busy(ws_busy), .done(ws_done)
  );
  dct_nck_counter u_wrec (
    .clk(clk), .rst(rst), .load(rc_load), .load_val(rc_val), .tick(ck_rise),
    .count(), .busy(rc_busy), .done(rc_done)
  );
  dct_nck_counter u_ops (
    .clk(clk), .rst(rst), .load(op_load), .load_val(op_val), .tick(ck_rise),
    .count(op_count), .busy(ops_busy), .done()
  );
  dct_nck_counter u_zq (
    .clk(clk), .rst(rst), .load(zq_load), .load_val(dct_pkg::ZQCS_NCK),
    .tick(ck_rise), .count(), .busy(zq_busy), .done(zq_done)
  );

  // ----------------------------------------------------------------
  // Mode, write pipeline, trim and power-down state
  // ----------------------------------------------------------------
  logic [1:0] bl_ff, nxt_bl, al_ff, nxt_al;
  logic [2:0] cl_ff, nxt_cl, wr_ff, nxt_wr, cwl_ff, nxt_cwl;
  logic       ap_pend_ff, nxt_ap_pend;
  logic [2:0] wbank_ff, nxt_wbank, apb_ff, nxt_apb;
  logic [5:0] trim_ff, nxt_trim;
  logic       cke_ff, nxt_cke, pd_ff, nxt_pd;
  logic [7:0] cl_n, wl_n, op_new;

  // Write latency is CWL plus additive latency
  always_comb begin
    cl_n = dct_pkg::CL_BASE + {5'h00, cl_ff};
    case (al_ff)
      dct_pkg::AL_CL1: wl_n = dct_pkg::CWL_BASE + {5'h00, cwl_ff} + cl_n - 8'h01;
      dct_pkg::AL_CL2: wl_n = dct_pkg::CWL_BASE + {5'h00, cwl_ff} + cl_n - 8'h02;
      default:         wl_n = dct_pkg::CWL_BASE + {5'h00, cwl_ff};
    endcase
  end

  // Next state of everything the decoded commands steer
  always_comb begin
    nxt_bl      = bl_ff;
    nxt_al      = al_ff;
    nxt_cl      = cl_ff;
    nxt_wr      = wr_ff;
    nxt_cwl     = cwl_ff;
    nxt_ap_pend = ap_pend_ff;
    nxt_wbank   = wbank_ff;
    nxt_apb     = apb_ff;
    nxt_trim    = trim_ff;
    nxt_cke     = cke_ff;
    nxt_pd      = pd_ff;
    ws_load     = 1'b0;
    ws_val      = 8'h00;
    rc_load     = 1'b0;
    rc_val      = dct_pkg::wr_code_nck(wr_ff);
    zq_load     = 1'b0;
    op_new      = 8'h00;
    if (cmd == dct_pkg::CMD_MRS) begin
      case (ba_s[1:0])
        dct_pkg::MRSEL_0: begin
          nxt_bl = a_s[dct_pkg::MR0_BL_LSB +: 2];
          nxt_cl = a_s[dct_pkg::MR0_CL_LSB +: 3];
          nxt_wr = a_s[dct_pkg::MR0_WR_LSB +: 3];
        end
        dct_pkg::MRSEL_1: nxt_al  = a_s[dct_pkg::MR1_AL_LSB +: 2];
        dct_pkg::MRSEL_2: nxt_cwl = a_s[dct_pkg::MR2_CWL_LSB +: 3];
        default: ;
      endcase
    end
    // Only fixed chop-4 starts early; a newer write restarts the timer
    if (cmd == dct_pkg::CMD_WR) begin
      ws_load     = 1'b1;
      ws_val      = wl_n + ((bl_ff == dct_pkg::BL_BC4) ? dct_pkg::WSTART_BC4
                                                       : dct_pkg::WSTART_BL8);
      nxt_ap_pend = a_s[dct_pkg::A_AP];
      nxt_wbank   = ba_s;
    end
    // Recovery runs from the internal write start
    if (ws_done && ap_pend_ff) begin
      rc_load     = 1'b1;
      nxt_ap_pend = (cmd == dct_pkg::CMD_WR) ? a_s[dct_pkg::A_AP] : 1'b0;
    end
    if (rc_done) begin
      nxt_apb = wbank_ff;
      op_new  = dct_pkg::TRP_NCK;
    end
    // Row work keeps the longest remaining time
    case (cmd)
      dct_pkg::CMD_ACT: op_new = (op_new > dct_pkg::TRCD_NCK) ? op_new : dct_pkg::TRCD_NCK;
      dct_pkg::CMD_PRE: op_new = (op_new > dct_pkg::TRP_NCK) ? op_new : dct_pkg::TRP_NCK;
      dct_pkg::CMD_REF: op_new = (op_new > dct_pkg::TRFC_NCK) ? op_new : dct_pkg::TRFC_NCK;
      default: ;
    endcase
    // Short calibration while one runs is ignored
    if ((cmd == dct_pkg::CMD_ZQ) && !a_s[dct_pkg::A_AP] && !zq_busy) begin
      zq_load = 1'b1;
    end
    if (zq_done) begin
      if (s3_ff[dct_pkg::P_ZQ]) begin
        nxt_trim = (trim_ff == dct_pkg::TRIM_MIN) ? trim_ff : trim_ff - 6'h01;
      end else begin
        nxt_trim = (trim_ff == dct_pkg::TRIM_MAX) ? trim_ff : trim_ff + 6'h01;
      end
    end
    // CKE low is taken at once, but low power waits for the work to end
    if (ck_rise) begin
      nxt_cke = s3_ff[dct_pkg::P_CKE];
    end
    nxt_pd = !cke_ff && !ops_busy && !ws_busy && !rc_busy && !zq_busy;
  end

  assign op_load = (op_new > op_count);
  assign op_val  = op_new;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bl_ff      <= dct_pkg::BL_RST;
      al_ff      <= dct_pkg::AL_RST;
      cl_ff      <= dct_pkg::CL_RST;
      wr_ff      <= dct_pkg::WR_RST;
      cwl_ff     <= dct_pkg::CWL_RST;
      ap_pend_ff <= 1'b0;
      wbank_ff   <= 3'h0;
      apb_ff     <= 3'h0;
      trim_ff    <= dct_pkg::TRIM_RST;
      cke_ff     <= 1'b0;
      pd_ff      <= 1'b0;
    end else begin
      bl_ff      <= nxt_bl;
      al_ff      <= nxt_al;
      cl_ff      <= nxt_cl;
      wr_ff      <= nxt_wr;
      cwl_ff     <= nxt_cwl;
      ap_pend_ff <= nxt_ap_pend;
      wbank_ff   <= nxt_wbank;
      apb_ff     <= nxt_apb;
      trim_ff    <= nxt_trim;
      cke_ff     <= nxt_cke;
      pd_ff      <= nxt_pd;
    end
  end

  assign wr_start  = ws_done;
  assign auto_pre  = rc_done;
  assign ap_bank   = apb_ff;
  assign zq_trim   = trim_ff;
  assign pd_active = pd_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] ws_edges_ff, ws_exp_ff, rc_edges_ff, zq_edges_ff;

  // Edge counts since each event, read only by the checks below
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_edges_ff <= 8'h00;
      ws_exp_ff   <= 8'h00;
      rc_edges_ff <= 8'h00;
      zq_edges_ff <= 8'h00;
    end else begin
      ws_edges_ff <= ws_load ? 8'h00 : ws_edges_ff + {7'h00, ck_rise};
      ws_exp_ff   <= ws_load ? ws_val : ws_exp_ff;
      rc_edges_ff <= rc_load ? 8'h00 : rc_edges_ff + {7'h00, ck_rise};
      zq_edges_ff <= zq_load ? 8'h00 : zq_edges_ff + {7'h00, ck_rise};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_zq_issue;
    zq_load;
  endsequence
  sequence s_zq_hold;
    zq_busy [*8];
  endsequence

  property p_wstart_time;
    wr_start |-> (ws_edges_ff + 8'h01 == ws_exp_ff);
  endproperty
  a_wstart_time: assert property (p_wstart_time) else $error("write start off its edge");

  property p_wstart_bc4;
    (cmd == dct_pkg::CMD_WR && bl_ff == dct_pkg::BL_BC4) |=> (ws_exp_ff == wl_n + 8'h02);
  endproperty
  a_wstart_bc4: assert property (p_wstart_bc4) else $error("chop4 start not WL+2");

  property p_zq_len;
    zq_done |-> (zq_edges_ff + 8'h01 == dct_pkg::ZQCS_NCK);
  endproperty
  a_zq_len: assert property (p_zq_len) else $error("short calibration not 64 edges");

  property p_zq_busy;
    s_zq_issue |=> s_zq_hold;
  endproperty
  a_zq_busy: assert property (p_zq_busy) else $error("calibration busy dropped early");

  property p_zq_step;
    (zq_done && !s3_ff[dct_pkg::P_ZQ] && trim_ff != dct_pkg::TRIM_MAX)
      |=> (trim_ff == $past(trim_ff) + 6'h01);
  endproperty
  a_zq_step: assert property (p_zq_step) else $error("trim did not step");

  property p_rec_time;
    auto_pre |-> (rc_edges_ff + 8'h01 == dct_pkg::wr_code_nck(wr_ff));
  endproperty
  a_rec_time: assert property (p_rec_time) else $error("recovery not MR0 cycles");

  property p_pd_waits;
    (ops_busy || zq_busy) |=> !pd_active;
  endproperty
  a_pd_waits: assert property (p_pd_waits) else $error("power-down during work");

  // Timers must keep counting link edges while clock enable is low
  property p_pd_finish;
    (ops_busy && !cke_ff && ck_rise && !op_load)
      |=> (op_count == $past(op_count) - 8'h01);
  endproperty
  a_pd_finish: assert property (p_pd_finish) else $error("work lost at power-down");

endmodule : dct_timing
`default_nettype wire

// ==== testbench/dct_ctl_model.sv ====
// Controller model: makes the link clock and drives commands on the pins.
// Assumes the bench calls send and power from its scenario tasks.
`timescale 1ns/1ps
`default_nettype none
module dct_ctl_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Memory pins
  output logic             ck,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [14:0]      addr
);
  localparam int TCK_PS = 80000;
  localparam int TMOD   = 12;  // Plain default, also covers the 4-edge MRS spacing
  localparam int TWR_PS = 15000; // Write recovery, plain default
  localparam int WL_MAX = 30;    // Worst write latency assumed before power-down
  localparam int TMPRR_NCK = 20; // Read burst end plus MPR recovery, plain default
  int half    = 8;  // Half link period in clk cycles; bench may stretch it
  int ph      = 0;
  int nck     = 0;  // Link rises so far
  int gap     = 0;  // Down counter blocking the next command
  int last    = 0;
  int pd_need = 0;

  // Rounded-up cycle count of a ps figure
  function automatic int ru(input int ps);
    return (ps + TCK_PS - 1) / TCK_PS;
  endfunction : ru

  // Pins idle and deselected at time zero
  initial begin
    {ck, cke, cs_n, ras_n, cas_n, we_n} = 6'h1F;
    ba = 3'h0;
    addr = 15'h0;
  end

  // Link clock runs through reset; spacings count edges, not time
  always @(posedge clk) begin
    if (ph + 1 >= half) begin
      ph <= 0;
      ck <= ~ck;
      if (!ck) begin
        nck <= nck + 1;
        if (gap > 0) gap <= gap - 1;
      end
    end else begin
      ph <= ph + 1;
    end
  end

  // One command, held from the fall before its rise to the fall after
  task automatic send(input dct_pkg::dct_cmd_t c, input logic [2:0] b,
                      input logic [14:0] a, output int at);
    logic [2:0] rcw;
    case (c)
      dct_pkg::CMD_MRS: rcw = 3'h0;
      dct_pkg::CMD_REF: rcw = 3'h1;
      dct_pkg::CMD_PRE: rcw = 3'h2;
      dct_pkg::CMD_ACT: rcw = 3'h3;
      dct_pkg::CMD_WR:  rcw = 3'h4;
      dct_pkg::CMD_RD:  rcw = 3'h5;
      dct_pkg::CMD_ZQ:  rcw = 3'h6;
      default:          rcw = 3'h7;
    endcase
    while (gap > 0) @(posedge clk);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= {1'h0, rcw};
    ba <= b;
    addr <= a;
    at = nck + 1;
    @(negedge ck);
    // Released pins show the inverse so a stale value never passes
    {cs_n, ras_n, cas_n, we_n} <= {1'h1, ~rcw};
    ba <= ~b;
    addr <= ~a;
    last = at;
    // Write to power-down rounds the recovery time up to whole cycles
    pd_need = (c == dct_pkg::CMD_MRS) ? TMOD
            : (c == dct_pkg::CMD_WR)  ? WL_MAX + 4 + ru(TWR_PS) : 1;
    // Blocking, so a send called in this same step already sees the spacing
    gap = (c == dct_pkg::CMD_MRS) ? TMOD
        : (c == dct_pkg::CMD_REF) ? ru(dct_pkg::TRFC_PS)
        : (c == dct_pkg::CMD_RD)  ? TMPRR_NCK : 0;
  endtask : send

  // Clock enable moves on a fall, once the entry delay is met
  task automatic power(input logic lvl);
    if (ck || ph != 0) @(negedge ck);
    while (nck + 1 - last < pd_need) @(negedge ck);
    cke <= lvl;
  endtask : power
endmodule : dct_ctl_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the DDR3 command timing block.
// Assumes the controller model drives every memory pin of the block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        zq_cmp_hi = 1'h0;
  logic        ck, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba, ap_bank;
  logic [14:0] addr;
  logic        wr_start, auto_pre, zq_busy, zq_done, ops_busy, pd_active;
  logic [5:0]  zq_trim;
  int          n_errors = 0;
  int          comparisons = 0;

  dct_ctl_model ctl (.clk, .rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
  dct_timing uut (.clk, .rst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .zq_cmp_hi, .wr_start, .auto_pre, .ap_bank, .zq_busy, .zq_done, .zq_trim,
    .ops_busy, .pd_active);

  // System clock, 5 ns
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch at %0t: %0d link edges, expected %0d", $time, got, exp);
    end
  endtask : chk_n

  // Bounded wait for a pulse; returns the link rise it belongs to
  task automatic wait_ev(input int sel, output int at);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk);
      if ((sel == 0 && wr_start === 1'h1) || (sel == 1 && auto_pre === 1'h1)
          || (sel == 2 && zq_done === 1'h1)) break;
    end
    at = ctl.nck;
  endtask : wait_ev

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic t_reset;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    chk(16'({wr_start, auto_pre, zq_busy, zq_done, ops_busy, pd_active, ap_bank}), 16'h0);
    chk(16'(zq_trim), 16'h20);
    rst <= 1'h0;
  endtask : t_reset

  // Program modes, write with auto-precharge, time start and recovery
  task automatic t_write(input logic [1:0] bl, input logic a12, input logic [2:0] cwl,
                         input logic [1:0] al, input logic [2:0] wr, input logic [2:0] b);
    int k, t1, t2, wl;
    int rec [8] = '{16, 5, 6, 7, 8, 10, 12, 14};
    wl = 5 + cwl + ((al == 2'h1) ? 4 : (al == 2'h2) ? 3 : 0);  // CL stays 5
    ctl.send(dct_pkg::CMD_MRS, 3'h0, 15'({wr, 2'h0, 3'h1, 2'h0, bl}), k);
    ctl.send(dct_pkg::CMD_MRS, 3'h1, 15'({al, 3'h0}), k);
    ctl.send(dct_pkg::CMD_MRS, 3'h2, 15'({cwl, 3'h0}), k);
    ctl.send(dct_pkg::CMD_WR, b, 15'({a12, 1'h0, 1'h1, 10'h0}), k);
    wait_ev(0, t1);
    chk_n(t1 - k, wl + ((bl == dct_pkg::BL_BC4) ? 2 : 4));
    wait_ev(1, t2);
    chk_n(t2 - t1, rec[wr]);
    @(posedge clk);
    chk(16'(ap_bank), 16'(b));
  endtask : t_write

  // Refused calibrations, 64-edge finish, one trim step each way
  task automatic t_zq;
    int z, t;
    logic [5:0] mid;
    zq_cmp_hi <= 1'h1;
    ctl.send(dct_pkg::CMD_ZQ, 3'h0, 15'h0400, z);
    repeat (8) @(posedge clk);
    chk(16'(zq_busy), 16'h0);
    ctl.send(dct_pkg::CMD_ZQ, 3'h0, 15'h0, z);
    ctl.send(dct_pkg::CMD_ZQ, 3'h0, 15'h0, t);
    chk(16'(zq_busy), 16'h1);
    wait_ev(2, t);
    chk_n(t - z, 64);
    repeat (2) @(posedge clk);
    mid = zq_trim;
    chk(16'(zq_busy), 16'h0);
    chk(16'(mid), 16'(dct_pkg::TRIM_RST - 6'h01));
    zq_cmp_hi <= 1'h0;
    ctl.send(dct_pkg::CMD_ZQ, 3'h0, 15'h0, z);
    wait_ev(2, t);
    repeat (2) @(posedge clk);
    chk(16'(zq_trim), 16'h20);
  endtask : t_zq

  // Row timers, then clock enable low one edge after refresh, while refresh still runs
  task automatic t_pd;
    int r;
    ctl.send(dct_pkg::CMD_ACT, 3'h2, 15'h0, r);
    chk(16'(ops_busy), 16'h1);
    ctl.send(dct_pkg::CMD_RD, 3'h2, 15'h0, r);
    chk(16'(ops_busy), 16'h0);
    ctl.send(dct_pkg::CMD_PRE, 3'h2, 15'h0, r);
    chk(16'(ops_busy), 16'h1);
    ctl.send(dct_pkg::CMD_REF, 3'h0, 15'h0, r);
    ctl.power(1'h0);
    @(posedge ck);
    repeat (6) @(posedge clk);
    chk(16'({ops_busy, pd_active}), 16'h2);
    repeat (2) @(posedge ck);
    repeat (6) @(posedge clk);
    chk(16'({ops_busy, pd_active}), 16'h1);
    ctl.power(1'h1);
    repeat (2) @(posedge ck);
    repeat (6) @(posedge clk);
    chk(16'(pd_active), 16'h0);
  endtask : t_pd

  // Main sequence; second reset lands in mid-calibration
  initial begin
    int i;
    int z;
    t_reset;
    for (i = 0; i < 8; i++) begin
      t_write(2'(i % 3), i[0], 3'(i % 5), 2'((i / 3) % 3), 3'(i), 3'(7 - i));
    end
    @(negedge clk);
    ctl.half = 30;
    t_write(dct_pkg::BL_FIX8, 1'h0, 3'h2, 2'h0, 3'h3, 3'h5);
    @(negedge clk);
    ctl.half = 8;
    ctl.send(dct_pkg::CMD_ZQ, 3'h0, 15'h0, z);
    repeat (100) @(posedge clk);
    t_reset;
    t_zq;
    t_pd;
    end_of_test;
  end

  // Watchdog, well beyond the expected run
  initial begin
    #400000;
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    end_of_test;
  end
endmodule : tb
`default_nettype wire
